/* File: input_ov_fault_retry.sv */
`include "input_ov_fault_retry_regs.svh"

module input_ov_fault_retry #(
	parameter int unsigned MS_CYCLES = `OVR_MS_CYCLES
) (
	// Clock and reset
	input  wire logic                    mclk_in,
	input  wire logic                    rst_b_in,
	// Configuration register port
	input  wire logic [`OVR_ADDR_W-1:0]  cfg_addr_in,
	input  wire logic                    cfg_wr_in,
	input  wire logic [`OVR_DATA_W-1:0]  cfg_wdata_in,
	output logic      [`OVR_DATA_W-1:0]  cfg_rdata_out,
	// Fault and supply pins
	input  wire logic                    ov_fault_in,
	input  wire logic                    bias_lost_in,
	// Status
	output logic                         output_en_out,
	output logic                         latched_out
);

	// Second delay table is irregular, so it stays a lookup
	function automatic logic [`OVR_MS_W-1:0] delay2_ms(input logic [2:0] code);
		logic [`OVR_MS_W-1:0] v;
		v = `OVR_D2_0_MS;
		unique case (code)
			3'h0: v = `OVR_D2_0_MS;
			3'h1: v = `OVR_D2_1_MS;
			3'h2: v = `OVR_D2_2_MS;
			3'h3: v = `OVR_D2_3_MS;
			3'h4: v = `OVR_D2_4_MS;
			3'h5: v = `OVR_D2_5_MS;
			3'h6: v = `OVR_D2_6_MS;
			3'h7: v = `OVR_D2_7_MS;
		endcase
		return v;
	endfunction : delay2_ms

	function automatic logic [`OVR_MS_W-1:0] delay1_ms(input logic [2:0] code);
		return `OVR_MS_W'(`OVR_D1_BASE_MS << code);
	endfunction : delay1_ms

	localparam logic [`OVR_PRE_W-1:0] PRE_LAST = `OVR_PRE_W'(MS_CYCLES - 1);

	// Pin synchronisers
	logic [1:0] fault_sync_r;
	logic [1:0] bias_sync_r;
	logic       fault_s;
	logic       bias_lost_s;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fault_sync_r <= 2'h0;
			bias_sync_r  <= 2'h0;
		end else begin
			fault_sync_r <= {fault_sync_r[0], ov_fault_in};
			bias_sync_r  <= {bias_sync_r[0], bias_lost_in};
		end
	end

	assign fault_s     = fault_sync_r[1];
	assign bias_lost_s = bias_sync_r[1];

	// Configuration register
	logic [`OVR_DATA_W-1:0] action_r;
	logic [`OVR_DATA_W-1:0] action_nxt;
	logic [`OVR_DATA_W-1:0] rdata_r;
	logic [`OVR_DATA_W-1:0] rdata_nxt;
	logic                   sel;

	always_comb begin
		sel        = (cfg_addr_in == `OVR_ACTION_OFFSET);
		action_nxt = action_r;
		if (cfg_wr_in && sel) begin
			action_nxt = cfg_wdata_in;
		end
		// Unmapped addresses read as zero
		rdata_nxt = sel ? action_r : `OVR_DATA_W'(0);
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			action_r <= `OVR_ACTION_RESET;
			rdata_r  <= `OVR_DATA_W'(0);
		end else begin
			action_r <= action_nxt;
			rdata_r  <= rdata_nxt;
		end
	end

	assign cfg_rdata_out = rdata_r;

	ov_retry_pkg::resp_t resp;
	logic [2:0]          retry_code;
	logic [2:0]          delay_code;

	assign resp       = ov_retry_pkg::resp_t'(action_r[`OVR_RESP_HI:`OVR_RESP_LO]);
	assign retry_code = action_r[`OVR_RETRY_HI:`OVR_RETRY_LO];
	assign delay_code = action_r[`OVR_DELAY_HI:`OVR_DELAY_LO];

	// Sequencer
	ov_retry_pkg::state_t     state_r;
	ov_retry_pkg::state_t     state_nxt;
	logic [`OVR_PRE_W-1:0]    pre_r;
	logic [`OVR_PRE_W-1:0]    pre_nxt;
	logic [`OVR_MS_W-1:0]     ms_r;
	logic [`OVR_MS_W-1:0]     ms_nxt;
	logic [2:0]               left_r;
	logic [2:0]               left_nxt;
	logic                     en_r;
	logic                     en_nxt;
	logic                     ms_tick;
	logic                     d1_done;
	logic                     d2_done;
	logic                     unlimited;

	always_comb begin
		ms_tick   = (pre_r == PRE_LAST);
		d1_done   = ms_tick && (ms_r + 12'h001 >= delay1_ms(delay_code));
		d2_done   = ms_tick && (ms_r + 12'h001 >= delay2_ms(delay_code));
		unlimited = (retry_code == `OVR_RETRY_INF);
		state_nxt = state_r;
		en_nxt    = en_r;
		left_nxt  = left_r;
		// Timebase runs in every state except run and latched, which hold it at zero
		pre_nxt   = ms_tick ? `OVR_PRE_W'(0) : pre_r + `OVR_PRE_W'(1);
		ms_nxt    = ms_tick ? ms_r + 12'h001 : ms_r;
		unique case (state_r)
			ov_retry_pkg::ST_RUN: begin
				pre_nxt = `OVR_PRE_W'(0);
				ms_nxt  = 12'h000;
				en_nxt  = 1'b1;
				// Fresh budget only once the fault has gone away
				if (!fault_s) begin
					left_nxt = retry_code;
				end else begin
					unique case (resp)
						ov_retry_pkg::RESP_IGNORE: state_nxt = ov_retry_pkg::ST_RUN;
						ov_retry_pkg::RESP_DELAY_RETRY: state_nxt = ov_retry_pkg::ST_DELAY1;
						ov_retry_pkg::RESP_SHUTDOWN_RETRY: begin
							en_nxt    = 1'b0;
							state_nxt = ov_retry_pkg::ST_OFF_WAIT;
						end
						ov_retry_pkg::RESP_WAIT_CLEAR: begin
							en_nxt    = 1'b0;
							state_nxt = ov_retry_pkg::ST_HOLD_OFF;
						end
					endcase
				end
			end
			ov_retry_pkg::ST_DELAY1: begin
				if (!fault_s) begin
					state_nxt = ov_retry_pkg::ST_RUN;
				end else if (d1_done) begin
					en_nxt    = 1'b0;
					pre_nxt   = `OVR_PRE_W'(0);
					ms_nxt    = 12'h000;
					state_nxt = ov_retry_pkg::ST_OFF_WAIT;
				end
			end
			ov_retry_pkg::ST_OFF_WAIT: begin
				if (d2_done) begin
					if (unlimited || left_r != 3'h0) begin
						en_nxt    = 1'b1;
						left_nxt  = unlimited ? left_r : left_r - 3'h1;
						state_nxt = ov_retry_pkg::ST_RUN;
					end else if (fault_s) begin
						state_nxt = ov_retry_pkg::ST_LATCHED;
					end else begin
						en_nxt    = 1'b1;
						state_nxt = ov_retry_pkg::ST_RUN;
					end
				end
			end
			ov_retry_pkg::ST_HOLD_OFF: begin
				if (!fault_s) begin
					en_nxt    = 1'b1;
					state_nxt = ov_retry_pkg::ST_RUN;
				end
			end
			ov_retry_pkg::ST_LATCHED: begin
				en_nxt  = 1'b0;
				pre_nxt = `OVR_PRE_W'(0);
				ms_nxt  = 12'h000;
			end
		endcase
		// Bias loss acts like a power cycle
		if (bias_lost_s) begin
			state_nxt = ov_retry_pkg::ST_RUN;
			en_nxt    = 1'b1;
			pre_nxt   = `OVR_PRE_W'(0);
			ms_nxt    = 12'h000;
			left_nxt  = retry_code;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= ov_retry_pkg::ST_RUN;
			en_r    <= 1'b1;
			pre_r   <= `OVR_PRE_W'(0);
			ms_r    <= 12'h000;
			left_r  <= 3'h0;
		end else begin
			state_r <= state_nxt;
			en_r    <= en_nxt;
			pre_r   <= pre_nxt;
			ms_r    <= ms_nxt;
			left_r  <= left_nxt;
		end
	end

	assign output_en_out = en_r;
	assign latched_out   = (state_r == ov_retry_pkg::ST_LATCHED);

endmodule : input_ov_fault_retry

/* File: input_ov_fault_retry_regs.svh */
`ifndef INPUT_OV_FAULT_RETRY_REGS_SVH
`define INPUT_OV_FAULT_RETRY_REGS_SVH

`define OVR_ADDR_W        8
`define OVR_DATA_W        8
`define OVR_ACTION_OFFSET 8'h56
`define OVR_ACTION_RESET  8'h00
`define OVR_RESP_HI       7
`define OVR_RESP_LO       6
`define OVR_RETRY_HI      5
`define OVR_RETRY_LO      3
`define OVR_DELAY_HI      2
`define OVR_DELAY_LO      0
`define OVR_RETRY_INF     3'h7
`define OVR_MS_NS         1000000
`define OVR_CLK_PERIOD_NS 40
`define OVR_MS_CYCLES     (`OVR_MS_NS / `OVR_CLK_PERIOD_NS)
`define OVR_PRE_W         15
`define OVR_MS_W          12
`define OVR_D1_BASE_MS    12'h00a
`define OVR_D2_0_MS       12'h0fc
`define OVR_D2_1_MS       12'h22e
`define OVR_D2_2_MS       12'h39c
`define OVR_D2_3_MS       12'h4ec
`define OVR_D2_4_MS       12'h63c
`define OVR_D2_5_MS       12'h78c
`define OVR_D2_6_MS       12'h8dc
`define OVR_D2_7_MS       12'ha2c

`endif

/* File: ov_retry_pkg.sv */
package ov_retry_pkg;
	typedef enum logic [1:0] {
		RESP_IGNORE,
		RESP_DELAY_RETRY,
		RESP_SHUTDOWN_RETRY,
		RESP_WAIT_CLEAR
	} resp_t;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_DELAY1,
		ST_OFF_WAIT,
		ST_HOLD_OFF,
		ST_LATCHED
	} state_t;
endpackage : ov_retry_pkg

/* File: input_ov_fault_retry_assertions.sv */
module ov_chk (
	// Watched ports
	input wire logic       mclk_in,
	input wire logic       rst_b_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic       cfg_wr_in,
	input wire logic [7:0] cfg_wdata_in,
	input wire logic [7:0] cfg_rdata_out,
	input wire logic       ov_fault_in,
	input wire logic       bias_lost_in,
	input wire logic       output_en_out,
	input wire logic       latched_out
);
	logic [7:0] act_r;
	logic [7:0] act_nxt;
	// Shadow of the action byte
	always_comb act_nxt = (cfg_wr_in && cfg_addr_in == 8'h56) ? cfg_wdata_in : act_r;
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) act_r <= 8'h00;
		else act_r <= act_nxt;
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	reset_idle_a: assert property ($rose(rst_b_in) |-> output_en_out && !latched_out)
		else $error("idle");
	latch_off_a: assert property (latched_out |-> !output_en_out)
		else $error("latch on");
	latch_hold_a: assert property ((!bias_lost_in)[*3] ##0 latched_out |=> latched_out)
		else $error("latch lost");
	bias_clear_a: assert property (bias_lost_in[*3] |=> output_en_out && !latched_out)
		else $error("bias");
	ignore_fault_a: assert property (act_r[7:6] == 2'b00 && output_en_out |=> output_en_out)
		else $error("ignore");
	fast_shut_a: assert property (act_r[7] && output_en_out
		&& $rose(ov_fault_in) ##1 ov_fault_in[*2] |=> !output_en_out) else $error("shut");
	delay_on_a: assert property (act_r[7:6] == 2'b01 && output_en_out
		&& $rose(ov_fault_in) |=> output_en_out[*8]) else $error("delay");
	clear_on_a: assert property (act_r[7:6] == 2'b11 && !latched_out
		##0 (!ov_fault_in)[*3] |=> output_en_out) else $error("reenable");
	read_back_a: assert property (cfg_addr_in == 8'h56 |=> cfg_rdata_out == $past(act_r))
		else $error("read back");
	read_unmapped_a: assert property (cfg_addr_in != 8'h56 |=> cfg_rdata_out == 8'h00)
		else $error("read unmapped");
	cover property (latched_out);
	cover property ($rose(output_en_out));
	cover property (bias_lost_in && latched_out);
endmodule : ov_chk

bind input_ov_fault_retry ov_chk u_chk (.mclk_in, .rst_b_in, .cfg_addr_in, .cfg_wr_in,
	.cfg_wdata_in, .cfg_rdata_out, .ov_fault_in, .bias_lost_in, .output_en_out, .latched_out);

/* File: tb_input_ov_fault_retry.sv */
`define CHK(x, y) begin compares++; if ((x) !== (y)) begin err_count++; \
	$display("[ERR] %0t mismatch", $time); end end
module tb_input_ov_fault_retry;
	timeunit 1ns;
	timeprecision 1ns;
	// Short ms keeps the longest retry run near 8k cycles
	localparam int MS = 2;
	logic       clk = 0, rst_b = 0, wr = 0, flt = 0, bias = 0, pe;
	logic [7:0] addr = 8'h00, wd = 8'h00, rd;
	logic       en, lat;
	int         err_count = 0, compares = 0, rises, offs;
	always #20 clk = ~clk;
	input_ov_fault_retry #(.MS_CYCLES(MS)) dut (.mclk_in(clk), .rst_b_in(rst_b),
		.cfg_addr_in(addr), .cfg_wr_in(wr), .cfg_wdata_in(wd), .cfg_rdata_out(rd),
		.ov_fault_in(flt), .bias_lost_in(bias), .output_en_out(en), .latched_out(lat));
	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic summarize();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	// Write, then read back with the address held
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		tick(1);
		wr <= 1'b0;
		tick(1);
		#1;
		`CHK(rd, (a == 8'h56) ? d : 8'h00)
		@(posedge clk);
	endtask : wr_reg
	function automatic int off_time(logic [7:0] a);
		int t[8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};
		return (a[5:3] + 1) * t[a[2:0]] * MS;
	endfunction : off_time
	// Fault held throughout; count restarts and off time
	task automatic run(logic [7:0] a, int lim);
		int ons;
		int k;
		ons = 0;
		rises = 0;
		offs = 0;
		pe = 1'b1;
		k = 8 * (a[5:3] + 1);
		wr_reg(8'h56, a);
		flt <= 1'b1;
		repeat (lim) begin
			@(posedge clk);
			#1;
			offs += !en;
			ons += en && offs == 0;
			rises += en && !pe;
			pe = en;
			if (lat) break;
		end
		if (a[7:6] == 2'b01) `CHK(ons inside {[(10 << a[2:0]) * MS : (10 << a[2:0]) * MS + 5]}, 1'b1)
		@(posedge clk);
		flt <= 1'b0;
		if (a[5:3] == 3'h7) begin
			`CHK(lat || rises < 3, 1'b0)
			rst_b <= 1'b0;
			tick(2);
			#1;
			`CHK({en, lat}, 2'b10)
			@(posedge clk);
			rst_b <= 1'b1;
		end else begin
			`CHK({lat, rises}, {1'b1, 32'(a[5:3])})
			`CHK(offs inside {[off_time(a) - k : off_time(a) + k]}, 1'b1)
			tick(20);
			#1;
			`CHK(lat, 1'b1)
			@(posedge clk);
			bias <= 1'b1;
			tick(4);
			bias <= 1'b0;
			tick(1);
			#1;
			`CHK({en, lat}, 2'b10)
		end
		$display("run %h done", a);
		@(posedge clk);
	endtask : run
	initial begin
		// All tests need under 50k cycles
		#(40 * 60000);
		err_count++;
		summarize();
	end
	initial begin
		void'($urandom(22552));
		tick(10);
		rst_b <= 1'b1;
		tick(1);
		#1;
		`CHK({en, lat, rd}, 10'h200)
		wr_reg(8'h55, 8'($urandom));
		wr_reg(8'h56, 8'h00);
		flt <= 1'b1;
		tick(30);
		#1;
		`CHK(en, 1'b1)
		wr_reg(8'h56, 8'hc0);
		tick(20);
		#1;
		`CHK(en, 1'b0)
		@(posedge clk);
		flt <= 1'b0;
		tick(4);
		#1;
		`CHK({en, lat}, 2'b10)
		$display("register, ignore, wait-clear done");
		for (int i = 0; i < 4; i++) begin
			run({2'b01 + 2'($urandom % 2), 3'($urandom % 3), 3'($urandom % 4)}, 20000);
		end
		// Long delay codes once; no retries keeps the run short
		run({2'b01 + 2'($urandom % 2), 3'h0, 3'h4 + 3'($urandom % 4)}, 12000);
		// Unlimited restarts, then six, the top finite count
		run(8'hb8, 3200);
		run(8'hb0, 8000);
		summarize();
	end
endmodule : tb_input_ov_fault_retry
